//--- ppcs_defs.svh
// Constants for the pixel port, pipeline and clock select block
// Assumes inclusion by the package, the block module, the controller model and the bench
`ifndef PPCS_DEFS_SVH
`define PPCS_DEFS_SVH
`define PPCS_PIX_W 16
`define PPCS_ADDR_W 8
`define PPCS_COL_W 18
`define PPCS_DAC_W 8
`define PPCS_PLL_N 8
`define PPCS_DIV_W 8
`define PPCS_MASK_RST 8'hff
`define PPCS_VDIV_RST 8'h01
`define PPCS_MDIV_RST 8'h02
`define PPCS_SENSE_HI_MV 10'h181
`define PPCS_SENSE_LO_MV 10'h113
`define PPCS_FULL_MV 10'h2bc
`endif

//--- ppcs_pkg.sv
// Types for the pixel port block
// Assumes the constants header is available
`include "ppcs_defs.svh"
package ppcs_pkg;
  typedef enum logic [1:0] {PPCS_PALETTE, PPCS_HIGH16, PPCS_DIRECT24} ppcs_mode_e;
  typedef struct packed {
    logic [`PPCS_PIX_W-1:0] pix;
    logic blank_n;
    logic secondary;
  } ppcs_pix_s;
  typedef struct packed {
    logic [`PPCS_DAC_W-1:0] r;
    logic [`PPCS_DAC_W-1:0] g;
    logic [`PPCS_DAC_W-1:0] b;
    logic blank_n;
  } ppcs_rgb_s;
endpackage

//--- ppcs_pixel_port.sv
// Pixel port, three-stage pipeline, blanking and clock selection
// Assumes pixel clock and pins are asynchronous; sampled by i_clk_sys
`timescale 1ns/1ps
`include "ppcs_defs.svh"
module ppcs_pixel_port
  import ppcs_pkg::*;
(
  // System
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Pixel link pins
  input wire logic i_pclk,
  input wire logic [`PPCS_PIX_W-1:0] i_pixel_bus,
  input wire logic i_blank_n,
  input wire logic i_colour_mode_switch,
  // Configuration
  input wire ppcs_mode_e i_primary_mode,
  input wire ppcs_mode_e i_secondary_mode,
  input wire logic [`PPCS_ADDR_W-1:0] i_pixel_mask,
  // Palette write port
  input wire logic i_pal_we,
  input wire logic [`PPCS_ADDR_W-1:0] i_pal_addr,
  input wire logic [`PPCS_COL_W-1:0] i_pal_data,
  // PLL entry programming
  input wire logic i_pll_we,
  input wire logic [2:0] i_pll_idx,
  input wire logic [`PPCS_DIV_W-1:0] i_pll_div,
  input wire logic [`PPCS_DIV_W-1:0] i_mem_div,
  // Clock select pins
  input wire logic i_freq_select_0,
  input wire logic i_freq_select_1,
  input wire logic i_select_strobe_n,
  // Output stream
  output logic o_out_valid,
  input wire logic i_out_ready,
  output ppcs_rgb_s o_rgb,
  output logic o_dac_power_down,
  output logic o_in_ready,
  // Clocks and sense
  output logic o_video_clock_out,
  output logic o_memory_clock_out,
  output logic [1:0] o_freq_sel,
  output logic o_sense_n
);

  function automatic logic [9:0] ppcs_mv(input logic [`PPCS_DAC_W-1:0] v);
    ppcs_mv = 10'((18'(v) * 18'(`PPCS_FULL_MV)) / 18'h000ff);
  endfunction

  // Any channel above the upper sense threshold
  function automatic logic ppcs_any_hi(input ppcs_rgb_s w);
    ppcs_any_hi = (ppcs_mv(w.r) > `PPCS_SENSE_HI_MV) || (ppcs_mv(w.g) > `PPCS_SENSE_HI_MV)
      || (ppcs_mv(w.b) > `PPCS_SENSE_HI_MV);
  endfunction

  // All channels below the lower sense threshold
  function automatic logic ppcs_all_lo(input ppcs_rgb_s w);
    ppcs_all_lo = (ppcs_mv(w.r) < `PPCS_SENSE_LO_MV) && (ppcs_mv(w.g) < `PPCS_SENSE_LO_MV)
      && (ppcs_mv(w.b) < `PPCS_SENSE_LO_MV);
  endfunction

  // Synchronisers
  logic [1:0] pclk_s, blk_s, msw_s, cs0_s, cs1_s, stb_s;
  logic [`PPCS_PIX_W-1:0] pix_s1, pix_s2;
  logic pclk_d, stb_d;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pclk_s <= 2'h0;
      blk_s <= 2'h0;
      msw_s <= 2'h0;
      cs0_s <= 2'h0;
      cs1_s <= 2'h0;
      stb_s <= 2'h3;
      pix_s1 <= 16'h0000;
      pix_s2 <= 16'h0000;
      pclk_d <= 1'b0;
      stb_d <= 1'b1;
    end
    else
    begin
      pclk_s <= {pclk_s[0], i_pclk};
      blk_s <= {blk_s[0], i_blank_n};
      msw_s <= {msw_s[0], i_colour_mode_switch};
      cs0_s <= {cs0_s[0], i_freq_select_0};
      cs1_s <= {cs1_s[0], i_freq_select_1};
      stb_s <= {stb_s[0], i_select_strobe_n};
      pix_s1 <= i_pixel_bus;
      pix_s2 <= pix_s1;
      pclk_d <= pclk_s[1];
      stb_d <= stb_s[1];
    end
  end

  wire pclk_rise = pclk_s[1] & ~pclk_d;
  wire stb_fall = stb_d & ~stb_s[1];

  // Stage 1: capture pixel and blank together
  ppcs_pix_s cap;
  logic cap_valid;
  wire cap_advance;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cap <= '0;
      cap_valid <= 1'b0;
    end
    else if (pclk_rise && cap_advance)
    begin
      cap <= '{pix: pix_s2, blank_n: blk_s[1], secondary: msw_s[1]};
      cap_valid <= 1'b1;
    end
  end

  // Palette memory
  logic [`PPCS_COL_W-1:0] palette [0:(1<<`PPCS_ADDR_W)-1];
  always_ff @(posedge i_clk_sys)
  begin
    if (i_pal_we)
      palette[i_pal_addr] <= i_pal_data;
  end

  wire ppcs_mode_e cur_mode = cap.secondary ? i_secondary_mode : i_primary_mode;
  wire [`PPCS_ADDR_W-1:0] pal_index = cap.pix[`PPCS_ADDR_W-1:0] & i_pixel_mask;
  wire [`PPCS_COL_W-1:0] pal_word = palette[pal_index];
  wire [`PPCS_DAC_W-1:0] lut_r = {pal_word[17:12], 2'h0};
  wire [`PPCS_DAC_W-1:0] lut_g = {pal_word[11:6], 2'h0};
  wire [`PPCS_DAC_W-1:0] lut_b = {pal_word[5:0], 2'h0};
  wire [`PPCS_DAC_W-1:0] hc_r = {cap.pix[15:11], 3'h0};
  wire [`PPCS_DAC_W-1:0] hc_g = {cap.pix[10:5], 2'h0};
  wire [`PPCS_DAC_W-1:0] hc_b = {cap.pix[4:0], 3'h0};
  wire [`PPCS_DAC_W-1:0] dc_r = cap.pix[15:8];
  wire [`PPCS_DAC_W-1:0] dc_g = cap.pix[7:0];
  wire [`PPCS_DAC_W-1:0] dc_b = cap.pix[7:0];
  wire is_pal = (cur_mode == PPCS_PALETTE);
  wire is_hc = (cur_mode == PPCS_HIGH16);
  wire [`PPCS_DAC_W-1:0] sel_r = is_pal ? lut_r : (is_hc ? hc_r : dc_r);
  wire [`PPCS_DAC_W-1:0] sel_g = is_pal ? lut_g : (is_hc ? hc_g : dc_g);
  wire [`PPCS_DAC_W-1:0] sel_b = is_pal ? lut_b : (is_hc ? hc_b : dc_b);

  // Stage 2: lookup result, Stage 3 held in two-entry buffer
  ppcs_rgb_s look;
  logic look_valid;
  ppcs_rgb_s buf_q [0:1];
  logic [1:0] buf_cnt;
  logic buf_wp, buf_rp;
  wire buf_push = pclk_rise && look_valid && (buf_cnt != 2'h2);
  wire buf_pop = o_out_valid && i_out_ready;
  assign o_in_ready = (buf_cnt != 2'h2);
  assign cap_advance = o_in_ready;
  assign o_out_valid = (buf_cnt != 2'h0);
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      look <= '0;
      look_valid <= 1'b0;
    end
    else if (pclk_rise && o_in_ready)
    begin
      look <= '{r: sel_r, g: sel_g, b: sel_b, blank_n: cap.blank_n};
      look_valid <= cap_valid;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (buf_push)
      buf_q[buf_wp] <= look;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      buf_cnt <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end
    else
    begin
      if (buf_push)
        buf_wp <= ~buf_wp;
      if (buf_pop)
        buf_rp <= ~buf_rp;
      buf_cnt <= 2'(buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop});
    end
  end

  // Output register with blanking
  wire ppcs_rgb_s head = buf_q[buf_rp];
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rgb <= '0;
      o_dac_power_down <= 1'b1;
      o_sense_n <= 1'b1;
    end
    else if (buf_pop)
    begin
      o_rgb <= head.blank_n ? head : '0;
      o_dac_power_down <= ~head.blank_n;
      if (head.blank_n && ppcs_any_hi(head))
        o_sense_n <= 1'b0;
      else if (!head.blank_n || ppcs_all_lo(head))
        o_sense_n <= 1'b1;
    end
  end

  // PLL entries and frequency select latch
  logic [`PPCS_DIV_W-1:0] pll_tab [0:`PPCS_PLL_N-1];
  logic [`PPCS_DIV_W-1:0] vcnt, mcnt;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < `PPCS_PLL_N; i++)
        pll_tab[i] <= `PPCS_VDIV_RST;
      o_freq_sel <= 2'h0;
    end
    else
    begin
      if (i_pll_we)
        pll_tab[i_pll_idx] <= i_pll_div;
      if (stb_fall)
        o_freq_sel <= {cs1_s[1], cs0_s[1]};
    end
  end

  wire [`PPCS_DIV_W-1:0] vdiv = pll_tab[{1'b0, o_freq_sel}];
  wire [`PPCS_DIV_W-1:0] mdiv = (i_mem_div == 8'h00) ? `PPCS_MDIV_RST : i_mem_div;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      vcnt <= 8'h00;
      mcnt <= 8'h00;
      o_video_clock_out <= 1'b0;
      o_memory_clock_out <= 1'b0;
    end
    else
    begin
      if (vcnt >= vdiv - 8'h01)
      begin
        vcnt <= 8'h00;
        o_video_clock_out <= ~o_video_clock_out;
      end
      else
        vcnt <= 8'(vcnt + 8'h01);
      if (mcnt >= mdiv - 8'h01)
      begin
        mcnt <= 8'h00;
        o_memory_clock_out <= ~o_memory_clock_out;
      end
      else
        mcnt <= 8'(mcnt + 8'h01);
    end
  end

endmodule // ppcs_pixel_port

//--- ppcs_pixel_port_asserts.sv
// Checker for the pixel port outputs
// Assumes binding into ppcs_pixel_port
`timescale 1ns/1ps
module ppcs_pixel_port_asserts
  import ppcs_pkg::*;
(
  // Inputs
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_freq_select_0,
  input wire logic i_freq_select_1,
  input wire logic i_select_strobe_n,
  input wire logic i_out_ready,
  // Outputs
  input wire logic o_out_valid,
  input wire ppcs_rgb_s o_rgb,
  input wire logic o_dac_power_down,
  input wire logic o_in_ready,
  input wire logic [1:0] o_freq_sel,
  input wire logic o_sense_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire pop = o_out_valid && i_out_ready;
  a_blank_black: assert property (!o_rgb.blank_n |-> {o_rgb.r, o_rgb.g, o_rgb.b} == 24'h0)
    else $error("blanked word not black");
  a_power_blank: assert property (o_dac_power_down == !o_rgb.blank_n)
    else $error("power down not tracking blank");
  a_sense_blank: assert property (!o_rgb.blank_n |-> o_sense_n)
    else $error("sense low while blanked");
  a_sense_bright: assert property (o_rgb.blank_n && o_rgb.r == 8'hff |-> !o_sense_n)
    else $error("sense high on full red");
  a_rgb_hold: assert property (!pop |=> $stable(o_rgb))
    else $error("output changed without pop");
  a_stall_keep: assert property (o_out_valid && !i_out_ready |=> o_out_valid)
    else $error("word lost in stall");
  a_empty_takes: assert property (!o_out_valid |-> o_in_ready)
    else $error("empty buffer refuses");
  a_sel_latch: assert property ($fell(i_select_strobe_n) |-> ##[1:6] o_freq_sel == {i_freq_select_1, i_freq_select_0})
    else $error("select not latched");
  a_sel_hold: assert property (i_select_strobe_n [*6] |=> $stable(o_freq_sel))
    else $error("select moved without strobe");
  c_pop_blank: cover property (pop && !o_rgb.blank_n);
  c_full: cover property (!o_in_ready);
  c_strobe: cover property ($fell(i_select_strobe_n));
endmodule // ppcs_pixel_port_asserts
bind ppcs_pixel_port ppcs_pixel_port_asserts u_chk (.*);

//--- ppcs_ctrl_model.sv
// Graphics controller model driving the pixel link
// Assumes the bench calls send; link clock idles low, blank idles asserted
`timescale 1ns/1ps
`include "ppcs_defs.svh"
module ppcs_ctrl_model
  import ppcs_pkg::*;
(
  // Link pins
  output logic o_pclk,
  output logic [`PPCS_PIX_W-1:0] o_pixel_bus,
  output logic o_blank_n,
  output logic o_colour_mode_switch
);
  initial {o_pclk, o_pixel_bus, o_blank_n, o_colour_mode_switch} = '0;
  task automatic send(input ppcs_pix_s p, input int gap);
    {o_pixel_bus, o_blank_n, o_colour_mode_switch} = p;
    #100 o_pclk = 1;
    #100 o_pclk = 0;
    o_pixel_bus = ~p.pix;
    o_blank_n = 0;
    #(gap);
  endtask
endmodule // ppcs_ctrl_model

//--- ppcs_pixel_port_test.sv
// Self-checking bench for the pixel port block
// Assumes the controller model drives the link pins
`timescale 1ns/1ps
`include "ppcs_defs.svh"
module ppcs_pixel_port_test;
  import ppcs_pkg::*;
  logic i_clk_sys = 0, i_resetn = 0, i_pclk, i_blank_n, i_colour_mode_switch, i_pal_we = 0, i_pll_we = 0;
  logic i_freq_select_0 = 0, i_freq_select_1 = 0, i_select_strobe_n = 1, i_out_ready = 0;
  logic [15:0] i_pixel_bus;
  ppcs_mode_e i_primary_mode = PPCS_PALETTE, i_secondary_mode = PPCS_PALETTE;
  logic [7:0] i_pixel_mask = 8'hff, i_pal_addr = 8'h0, i_pll_div = 8'h0, i_mem_div = 8'h03;
  logic [2:0] i_pll_idx = 3'h0;
  logic [17:0] i_pal_data = 18'h0;
  logic o_out_valid, o_dac_power_down, o_in_ready, o_video_clock_out, o_memory_clock_out, o_sense_n;
  logic [1:0] o_freq_sel;
  ppcs_rgb_s o_rgb;
  logic [17:0] pal [256];
  ppcs_rgb_s q[$];
  int err_total = 0, samples_checked = 0, stall = 0;
  ppcs_rgb_s e_out;
  logic sense_exp = 1'b1;
  function automatic int mv(input logic [7:0] v);
    return (v * `PPCS_FULL_MV) / 255;
  endfunction
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  ppcs_pixel_port dut (.*);
  ppcs_ctrl_model ctl (.o_pclk(i_pclk), .o_pixel_bus(i_pixel_bus), .o_blank_n(i_blank_n),
    .o_colour_mode_switch(i_colour_mode_switch));
  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_rgb(input ppcs_rgb_s e, input ppcs_rgb_s g);
    samples_checked++;
    if (g !== e) fail("colour word");
  endtask
  task automatic chk_v(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) fail("value");
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic ppcs_rgb_s expect_of(ppcs_pix_s p);
    ppcs_mode_e m;
    logic [17:0] e;
    m = p.secondary ? i_secondary_mode : i_primary_mode;
    e = pal[p.pix[7:0] & i_pixel_mask];
    if (!p.blank_n) return '0;
    if (m == PPCS_PALETTE) return {e[17:12], 2'h0, e[11:6], 2'h0, e[5:0], 2'h0, 1'b1};
    if (m == PPCS_HIGH16) return {p.pix[15:11], 3'h0, p.pix[10:5], 2'h0, p.pix[4:0], 3'h0, 1'b1};
    return {p.pix[15:8], p.pix[7:0], p.pix[7:0], 1'b1};
  endfunction
  function automatic logic ck(input bit m);
    return m ? o_memory_clock_out : o_video_clock_out;
  endfunction
  task automatic half(input bit m, input logic [7:0] e);
    logic v;
    int n;
    @(posedge i_clk_sys);
    v = ck(m);
    for (n = 0; n < 600 && ck(m) == v; n++) @(posedge i_clk_sys);
    v = ck(m);
    for (n = 0; n < 600 && ck(m) == v; n++) @(posedge i_clk_sys);
    chk_v(e, 8'(n));
  endtask
  task automatic pal_wr(input logic [7:0] a, input logic [17:0] d);
    @(posedge i_clk_sys);
    i_pal_we <= 1;
    i_pal_addr <= a;
    i_pal_data <= d;
    pal[a] = d;
    @(posedge i_clk_sys);
    i_pal_we <= 0;
  endtask
  task automatic px(input logic [15:0] v, input logic bl, input logic sec);
    ppcs_pix_s p;
    p = {v, bl, sec};
    q.push_back(expect_of(p));
    ctl.send(p, 100 * ($urandom % 3));
  endtask
  always @(posedge i_clk_sys) i_out_ready <= !stall && ($urandom % 4 != 0);
  always @(posedge i_clk_sys)
    if (o_out_valid && i_out_ready)
    begin
      #1;
      e_out = q.pop_front();
      chk_rgb(e_out, o_rgb);
      chk_v(!e_out.blank_n, o_dac_power_down);
      if (!e_out.blank_n || (mv(e_out.r) < `PPCS_SENSE_LO_MV && mv(e_out.g) < `PPCS_SENSE_LO_MV
          && mv(e_out.b) < `PPCS_SENSE_LO_MV))
        sense_exp = 1'b1;
      else if (mv(e_out.r) > `PPCS_SENSE_HI_MV || mv(e_out.g) > `PPCS_SENSE_HI_MV
          || mv(e_out.b) > `PPCS_SENSE_HI_MV)
        sense_exp = 1'b0;
      chk_v(sense_exp, o_sense_n);
    end
  initial
  begin
    void'($urandom(78));
    repeat (12) @(posedge i_clk_sys);
    i_resetn <= 1;
    repeat (4) @(posedge i_clk_sys);
    for (int i = 0; i < 256; i++) pal_wr(8'(i), 18'($urandom));
    for (int s = 0; s < 6; s++)
    begin
      @(posedge i_clk_sys);
      i_primary_mode <= ppcs_mode_e'(s % 3);
      i_secondary_mode <= ppcs_mode_e'((s + 1) % 3);
      i_pixel_mask <= 8'($urandom);
      @(posedge i_clk_sys);
      px(16'hffff, 1, 0);
      for (int k = 0; k < 12; k++) px(16'($urandom), $urandom % 5 != 0, 1'($urandom));
      repeat (2) px(16'h0, 0, 0);
      pal_wr(8'($urandom), 18'($urandom));
    end
    stall = 1;
    repeat (2) @(posedge i_clk_sys);
    repeat (2) px(16'h1234, 1, 0);
    repeat (3) @(posedge i_clk_sys);
    #1 chk_v(0, o_in_ready);
    ctl.send({16'h5a5a, 2'b10}, 0);
    stall = 0;
    repeat (2) px(16'h0, 0, 0);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge i_clk_sys);
      i_pll_we <= 1;
      i_pll_idx <= 3'(c);
      i_pll_div <= 8'(c + 2);
      @(posedge i_clk_sys);
      i_pll_we <= 0;
      {i_freq_select_1, i_freq_select_0} <= 2'(c);
      repeat (4) @(posedge i_clk_sys);
      i_select_strobe_n <= 0;
      repeat (4) @(posedge i_clk_sys);
      i_select_strobe_n <= 1;
      repeat (20) @(posedge i_clk_sys);
      chk_v(8'(c), o_freq_sel);
      half(0, 8'(c + 2));
    end
    half(1, 8'h03);
    repeat (40) @(posedge i_clk_sys);
    chk_v(8'h02, 8'(q.size()));
    report_and_stop;
  end
  initial
  begin
    #1ms;
    fail("timeout");
    report_and_stop;
  end
endmodule // ppcs_pixel_port_test
